// ===== hdl/tape_ctrl_map.svh
// Constants for the tape controller command decode.
// Assumes inclusion by bare name from the design files.
`ifndef TAPE_CTRL_MAP_SVH
`define TAPE_CTRL_MAP_SVH
// ==========================================
// Director codes
`define TC_DIR_XFER 2'h0
`define TC_DIR_CTRL 2'h1
`define TC_DIR_USEL 2'h2
`define TC_DIR_BUF 2'h3
// ==========================================
// Field positions
`define TC_SEL_ZERO_HI 15
`define TC_SEL_ZERO_LO 11
`define TC_EQ_HI 10
`define TC_EQ_LO 7
`define TC_CODE_HI 10
`define TC_CODE_LO 7
`define TC_CF_CLEAR 0
`define TC_UNIT_HI 8
`define TC_UNIT_LO 7
`define TC_USEL_BAD_HI 10
`define TC_USEL_BAD_LO 9
// ==========================================
// Motion codes
`define TC_MOT_NONE 4'h0
`define TC_MOT_WRITE 4'h1
`define TC_MOT_READ 4'h2
// ==========================================
// Reset values and timing
`define TC_WORD_RESET 16'h0000
`define TC_CLK_NS 25
`define TC_CONT_NS 200000
`define TC_CONT_CYC (`TC_CONT_NS / `TC_CLK_NS)
`endif

// ===== hdl/tape_ctrl_pkg.sv
// Types shared by the tape controller design files.
// Assumes nothing of its surroundings.
package tape_ctrl_pkg;
	typedef enum logic [2:0] {
		ST_IDLE, ST_FETCH, ST_ARMED, ST_WGAP, ST_WRITE, ST_RBLK, ST_READ, ST_EOR
	} state_e;
	typedef logic [15:0] word_t;
endpackage

// ===== hdl/pack_if.sv
// Link between command decode and the character packer.
// Assumes both ends run on one clock.
`timescale 1ns/100ps
interface pack_if;
	logic [15:0] word_in;
	logic word_stb;
	logic busy;
	logic [8:0] wchar;
	logic wstb;
	logic rd_en;
	logic [7:0] rchar;
	logic rstb;
	logic [15:0] rword;
	logic rdone;
	modport ctl(output word_in, word_stb, rd_en, rchar, rstb, input busy, wchar, wstb, rword, rdone);
	modport pk(input word_in, word_stb, rd_en, rchar, rstb, output busy, wchar, wstb, rword, rdone);
endinterface

// ===== hdl/char_pack.sv
// Word to tape character packer and unpacker with write parity.
// Assumes word strobes no closer than every second cycle.
`timescale 1ns/100ps
module char_pack (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Decode side
	pack_if.pk bus
);
	logic phase;
	logic [7:0] lo_hold;
	logic half;
	logic [7:0] hi_char;

	assign bus.busy = phase;

	// ==========================================
	// Write side: high character first, odd parity
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bus.wchar <= 9'h000;
			bus.wstb <= 1'b0;
			phase <= 1'b0;
			lo_hold <= 8'h00;
		end else begin
			bus.wstb <= 1'b0;
			if (phase) begin
				bus.wchar <= {~^lo_hold, lo_hold};
				bus.wstb <= 1'b1;
				phase <= 1'b0;
			end else if (bus.word_stb) begin
				bus.wchar <= {~^bus.word_in[15:8], bus.word_in[15:8]};
				bus.wstb <= 1'b1;
				lo_hold <= bus.word_in[7:0];
				phase <= 1'b1;
			end
		end
	end

	// ==========================================
	// Read side: two characters make one word
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			half <= 1'b0;
			hi_char <= 8'h00;
			bus.rword <= 16'h0000;
			bus.rdone <= 1'b0;
		end else begin
			bus.rdone <= 1'b0;
			if (!bus.rd_en) begin
				half <= 1'b0;
			end else if (bus.rstb) begin
				if (!half) begin
					hi_char <= bus.rchar;
					half <= 1'b1;
				end else begin
					bus.rword <= {hi_char, bus.rchar};
					bus.rdone <= 1'b1;
					half <= 1'b0;
				end
			end
		end
	end

	// ==========================================
	// Checks
	sequence s_two;
		bus.wstb ##1 bus.wstb;
	endsequence
	property p_parity;
		@(posedge clk) disable iff (!rst_b) bus.wstb |-> (^bus.wchar) == 1'b1;
	endproperty
	a_parity: assert property (p_parity) else $error("Write character parity not odd");
	property p_two;
		@(posedge clk) disable iff (!rst_b) bus.word_stb && !phase |=> s_two;
	endproperty
	a_two: assert property (p_two) else $error("Word did not give two characters");
endmodule

// ===== hdl/tape_ctrl_host_command_decode.sv
// Command decode and word transfer of a tape controller.
// Assumes host strobes on CLK; transport pins are asynchronous.
//
// Functional notes
// - Respond only when selector bits 7-10 equal the jumper equipment number.
// - Selector bits 2-6 are ignored in decoding.
// - Director 00 write/read, 01 control/status 1, 10 unit select/status 2.
// - Fitted jumper reads as 1, absent as 0, giving address 0 to F.
// - Output operations are further qualified by the accumulator word.
// - Unit select takes accumulator bits 8-7 to choose the transport.
// - Direct mode: motion function, then one instruction per data word.
// - Buffered: fetch end address before start, await motion, use storage channel.
// - Buffered read transfers only once the block is under the read head.
// - Buffered write transfers only after the pre-record gap has passed.
// - Each written character gets a computed parity bit.
// - Consecutive write outputs form one record whatever their count.
// - Broken write continuity starts an end-of-record sequence.
// - Direct write rejected: not ready, no write motion, no permit, buffered, protect.
// - Without a new control function tape halts at the next gap.
// - Host words are packed to and from tape characters.
// - Up to four transports on one chain can be addressed.
// - Write motion without buffered mode sets the transfer permit flag.
`include "tape_ctrl_map.svh"
`timescale 1ns/100ps
module tape_ctrl_host_command_decode
	import tape_ctrl_pkg::*;
#(
	parameter int CONT_CYCLES = `TC_CONT_CYC
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// Word channel
	input wire logic IO_OUT,
	input wire logic IO_IN,
	input wire logic [15:0] SEL_WORD,
	input wire logic [15:0] ACC_OUT,
	input wire logic PROTECT_FAULT,
	output logic REPLY,
	output logic REJECT,
	output logic [15:0] ACC_IN,
	// Equipment number jumpers
	input wire logic [3:0] EQUIP_JUMPER,
	// Direct storage channel
	output logic DSC_REQ,
	output logic DSC_WE,
	output logic [15:0] DSC_ADDR,
	output logic [15:0] DSC_WDATA,
	input wire logic [15:0] DSC_RDATA,
	input wire logic DSC_ACK,
	// Tape transport chain
	output logic [1:0] TT_UNIT,
	output logic TT_WRITE_MOTION,
	output logic TT_READ_MOTION,
	output logic TT_EOR,
	output logic [8:0] TT_WCHAR,
	output logic TT_WSTB,
	input wire logic [7:0] TT_RCHAR,
	input wire logic TT_RSTB,
	input wire logic TT_READY,
	input wire logic TT_GAP_DONE,
	input wire logic TT_BLOCK,
	input wire logic TT_AT_GAP
);
	localparam int NS = 17;
	localparam int CW = $clog2(CONT_CYCLES + 1);

	state_e state;
	logic [NS-1:0] pin_s1;
	logic [NS-1:0] pin_s2;
	logic rstb_d;
	logic [3:0] eq;
	logic ready, gap_done, block, at_gap;
	logic io, hit, ok, busy, halt;
	logic [1:0] dir;
	logic [3:0] code;
	logic [1:0] us_unit;
	logic wr_ok, rd_ok, cf_ok, us_ok, buf_ok, cf_clr, mot_w, mot_r;
	logic buffered, permit, word_avail;
	logic [CW-1:0] cont_cnt;
	logic cont_out;
	word_t cur_addr, end_addr, rd_word, in_word;
	pack_if pk();

	function automatic logic addressed(input logic [15:0] sel, input logic [3:0] num);
		addressed = (sel[`TC_SEL_ZERO_HI:`TC_SEL_ZERO_LO] == 5'h00)
			&& (sel[`TC_EQ_HI:`TC_EQ_LO] == num);
	endfunction

	// ==========================================
	// Pin synchronisers
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			rstb_d <= 1'b0;
		end else begin
			pin_s1 <= {EQUIP_JUMPER, TT_RCHAR, TT_RSTB, TT_READY, TT_GAP_DONE, TT_BLOCK, TT_AT_GAP};
			pin_s2 <= pin_s1;
			rstb_d <= pin_s2[4];
		end
	end
	assign eq = pin_s2[16:13];
	assign ready = pin_s2[3];
	assign gap_done = pin_s2[2];
	assign block = pin_s2[1];
	assign at_gap = pin_s2[0];
	// Character lines must be stable two clocks around their strobe
	assign pk.rchar = pin_s2[12:5];
	assign pk.rstb = pin_s2[4] & ~rstb_d;

	// ==========================================
	// Instruction decode
	assign io = IO_OUT | IO_IN;
	assign hit = io && addressed(SEL_WORD, eq);
	assign dir = SEL_WORD[1:0];
	assign code = ACC_OUT[`TC_CODE_HI:`TC_CODE_LO];
	assign us_unit = ACC_OUT[`TC_UNIT_HI:`TC_UNIT_LO];
	assign busy = (state != ST_IDLE) && (state != ST_ARMED);

	always_comb begin
		ok = 1'b0;
		case (dir)
		`TC_DIR_XFER: begin
			if (IO_OUT) begin
				ok = ready && TT_WRITE_MOTION && permit && !buffered && !PROTECT_FAULT
					&& !pk.busy && state == ST_WRITE;
			end else begin
				ok = TT_READ_MOTION && !buffered && word_avail;
			end
		end
		`TC_DIR_CTRL: begin
			if (IO_OUT) begin
				ok = !PROTECT_FAULT && (code == `TC_MOT_NONE || (ready && !busy
					&& (code == `TC_MOT_WRITE || code == `TC_MOT_READ)));
			end else begin
				ok = 1'b1;
			end
		end
		`TC_DIR_USEL: begin
			ok = IO_IN || (!PROTECT_FAULT && !busy
				&& ACC_OUT[`TC_USEL_BAD_HI:`TC_USEL_BAD_LO] == 2'h0);
		end
		default: begin
			ok = IO_IN || (!PROTECT_FAULT && state == ST_IDLE);
		end
		endcase
	end

	assign wr_ok = hit && IO_OUT && ok && dir == `TC_DIR_XFER;
	assign rd_ok = hit && IO_IN && ok && dir == `TC_DIR_XFER;
	assign cf_ok = hit && IO_OUT && ok && dir == `TC_DIR_CTRL;
	assign us_ok = hit && IO_OUT && ok && dir == `TC_DIR_USEL;
	assign buf_ok = hit && IO_OUT && ok && dir == `TC_DIR_BUF;
	assign cf_clr = cf_ok && ACC_OUT[`TC_CF_CLEAR];
	assign mot_w = cf_ok && code == `TC_MOT_WRITE;
	assign mot_r = cf_ok && code == `TC_MOT_READ;
	assign halt = at_gap && ((state == ST_EOR) || (state == ST_READ && !DSC_REQ));

	always_comb begin
		case (dir)
		`TC_DIR_XFER: in_word = rd_word;
		`TC_DIR_CTRL: in_word = {9'h000, word_avail, TT_READ_MOTION, TT_WRITE_MOTION,
			buffered, permit, busy, ready};
		`TC_DIR_USEL: in_word = {12'h000, busy, 1'b0, TT_UNIT};
		default: in_word = cur_addr;
		endcase
	end

	// ==========================================
	// Host answer
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			REPLY <= 1'b0;
			REJECT <= 1'b0;
			ACC_IN <= `TC_WORD_RESET;
		end else begin
			REPLY <= hit && ok;
			REJECT <= hit && !ok;
			if (hit && IO_IN && ok) begin
				ACC_IN <= in_word;
			end
		end
	end

	// ==========================================
	// Direct read word holding; a new word wins over the read
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rd_word <= `TC_WORD_RESET;
			word_avail <= 1'b0;
		end else begin
			if (rd_ok || cf_clr || us_ok) begin
				word_avail <= 1'b0;
			end
			if (pk.rdone && !buffered) begin
				rd_word <= pk.rword;
				word_avail <= 1'b1;
			end
		end
	end

	// ==========================================
	// Mode flags and transport lines
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			TT_WRITE_MOTION <= 1'b0;
			TT_READ_MOTION <= 1'b0;
			permit <= 1'b0;
			buffered <= 1'b0;
			TT_UNIT <= 2'h0;
		end else begin
			if (cf_clr || us_ok || halt) begin
				TT_WRITE_MOTION <= 1'b0;
				TT_READ_MOTION <= 1'b0;
				permit <= 1'b0;
				buffered <= 1'b0;
			end
			if (us_ok) begin
				TT_UNIT <= us_unit;
			end
			if (buf_ok) begin
				buffered <= 1'b1;
			end
			if (mot_w) begin
				TT_WRITE_MOTION <= 1'b1;
				permit <= !(buffered && !cf_clr);
			end
			if (mot_r) begin
				TT_READ_MOTION <= 1'b1;
			end
		end
	end

	// ==========================================
	// Continuity timer
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			cont_cnt <= '0;
		end else if (state != ST_WRITE || buffered || wr_ok) begin
			cont_cnt <= '0;
		end else if (!cont_out) begin
			cont_cnt <= cont_cnt + 1'b1;
		end
	end
	assign cont_out = cont_cnt == CW'(CONT_CYCLES);

	// ==========================================
	// Transfer sequencer
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			state <= ST_IDLE;
			cur_addr <= `TC_WORD_RESET;
			end_addr <= `TC_WORD_RESET;
			DSC_REQ <= 1'b0;
			DSC_WE <= 1'b0;
			DSC_ADDR <= `TC_WORD_RESET;
			DSC_WDATA <= `TC_WORD_RESET;
			TT_EOR <= 1'b0;
		end else begin
			TT_EOR <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (buf_ok) begin
					cur_addr <= ACC_OUT;
					DSC_ADDR <= ACC_OUT - 16'h0001;
					DSC_WE <= 1'b0;
					DSC_REQ <= 1'b1;
					state <= ST_FETCH;
				end
			end
			ST_FETCH: begin
				if (DSC_ACK) begin
					DSC_REQ <= 1'b0;
					end_addr <= DSC_RDATA;
					state <= ST_ARMED;
				end
			end
			ST_ARMED: begin
				state <= ST_ARMED;
			end
			ST_WGAP: begin
				if (gap_done) begin
					state <= ST_WRITE;
				end
			end
			ST_WRITE: begin
				if (buffered) begin
					if (DSC_ACK) begin
						DSC_REQ <= 1'b0;
						cur_addr <= cur_addr + 16'h0001;
					end else if (!DSC_REQ && !pk.busy) begin
						if (cur_addr == end_addr) begin
							TT_EOR <= 1'b1;
							state <= ST_EOR;
						end else begin
							DSC_ADDR <= cur_addr;
							DSC_WE <= 1'b0;
							DSC_REQ <= 1'b1;
						end
					end
				end else if (cont_out) begin
					TT_EOR <= 1'b1;
					state <= ST_EOR;
				end
			end
			ST_RBLK: begin
				if (block) begin
					state <= ST_READ;
				end
			end
			ST_READ: begin
				if (DSC_ACK) begin
					DSC_REQ <= 1'b0;
					cur_addr <= cur_addr + 16'h0001;
				end else if (buffered && pk.rdone && cur_addr != end_addr) begin
					DSC_ADDR <= cur_addr;
					DSC_WE <= 1'b1;
					DSC_WDATA <= pk.rword;
					DSC_REQ <= 1'b1;
				end
				if (halt) begin
					state <= ST_IDLE;
				end
			end
			ST_EOR: begin
				if (halt) begin
					state <= ST_IDLE;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
			if (cf_clr || us_ok) begin
				state <= ST_IDLE;
				DSC_REQ <= 1'b0;
			end
			if (mot_w) begin
				state <= ST_WGAP;
			end
			if (mot_r) begin
				state <= ST_RBLK;
			end
		end
	end

	// ==========================================
	// Packer
	assign pk.word_in = buffered ? DSC_RDATA : ACC_OUT;
	assign pk.word_stb = wr_ok || (state == ST_WRITE && buffered && DSC_ACK);
	assign pk.rd_en = state == ST_READ;
	assign TT_WCHAR = pk.wchar;
	assign TT_WSTB = pk.wstb;

	char_pack u_pack (
		.clk(CLK),
		.rst_b(RST_B),
		.bus(pk.pk)
	);

	// ==========================================
	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	sequence s_wr_req;
		hit && IO_OUT && dir == `TC_DIR_XFER;
	endsequence
	sequence s_eor_pulse;
		TT_EOR ##1 !TT_EOR;
	endsequence
	property p_addr_only;
		io && !addressed(SEL_WORD, eq) |=> !REPLY && !REJECT;
	endproperty
	a_addr_only: assert property (p_addr_only) else $error("Answered a foreign address");
	property p_one_answer;
		hit |=> REPLY != REJECT;
	endproperty
	a_one_answer: assert property (p_one_answer) else $error("Not exactly one answer");
	property p_wr_reject;
		s_wr_req ##0 (buffered || PROTECT_FAULT || !permit || !ready) |=> REJECT;
	endproperty
	a_wr_reject: assert property (p_wr_reject) else $error("Illegal write not rejected");
	property p_permit;
		mot_w && !buffered |=> permit && TT_WRITE_MOTION;
	endproperty
	a_permit: assert property (p_permit) else $error("Write motion left permit clear");
	property p_fetch;
		buf_ok |=> DSC_REQ && !DSC_WE && DSC_ADDR == $past(ACC_OUT) - 16'h0001;
	endproperty
	a_fetch: assert property (p_fetch) else $error("End address fetch wrong");
	property p_gap;
		state == ST_WGAP |-> !DSC_REQ && !pk.wstb;
	endproperty
	a_gap: assert property (p_gap) else $error("Write data before gap");
	property p_eor;
		state == ST_WRITE && !buffered && cont_out |=> s_eor_pulse;
	endproperty
	a_eor: assert property (p_eor) else $error("No end of record on timeout");
	property p_halt;
		state == ST_EOR && at_gap && !mot_w && !mot_r |=> !TT_WRITE_MOTION && state == ST_IDLE;
	endproperty
	a_halt: assert property (p_halt) else $error("Motion not halted at gap");
	property p_unit;
		us_ok |=> TT_UNIT == $past(us_unit);
	endproperty
	a_unit: assert property (p_unit) else $error("Unit not taken from accumulator");
	property p_clear;
		cf_clr && !mot_w && !mot_r |=> !buffered && !permit && state == ST_IDLE;
	endproperty
	a_clear: assert property (p_clear) else $error("Clear left state behind");
endmodule

// ===== verif/host_mem_model.sv
// Memory model on the far side of the direct storage channel.
// Assumes one clock shared with the controller; answers after 0 to 3 idle cycles.
`timescale 1ns/100ps
module host_mem_model #(
	parameter logic [15:0] START = 16'h0100,
	parameter logic [15:0] LAST = 16'h0103
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// Storage channel
	input wire logic DSC_REQ,
	input wire logic DSC_WE,
	input wire logic [15:0] DSC_ADDR,
	input wire logic [15:0] DSC_WDATA,
	output logic [15:0] DSC_RDATA,
	output logic DSC_ACK,
	// Traffic seen
	output logic [7:0] REQ_COUNT
);
	integer seed = 32'h0000_1d2b;
	logic [1:0] dly;
	// ==========================================
	// Answer
	// Writes are acknowledged and dropped; only fetches matter here
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			DSC_ACK <= 1'b0;
			DSC_RDATA <= 16'h0000;
			REQ_COUNT <= 8'h00;
			dly <= 2'h0;
		end else if (DSC_ACK) begin
			DSC_ACK <= 1'b0;
			DSC_RDATA <= ~DSC_RDATA; // Data is gone once ack is taken
		end else if (DSC_REQ) begin
			if (dly == 2'h0) begin
				DSC_ACK <= 1'b1;
				DSC_RDATA <= (DSC_ADDR == START - 16'h0001) ? LAST : DSC_ADDR ^ 16'h3c3c;
				REQ_COUNT <= REQ_COUNT + 8'h01;
				dly <= 2'($random(seed));
			end else begin
				dly <= dly - 2'h1;
			end
		end
	end
endmodule

// ===== verif/tape_ctrl_host_command_decode_tb_top.sv
// Self-checking bench for the tape controller command decode.
// Assumes the storage memory model; the bench plays host and transport.
`timescale 1ns/100ps
module tape_ctrl_host_command_decode_tb_top;
	import tape_ctrl_pkg::*;
	localparam int CONT = 40;
	logic clk = 1'b0, rst_b = 1'b0, io_out = 1'b0, io_in = 1'b0, protect_fault = 1'b0;
	logic [15:0] sel_word = 16'h0000, acc_out = 16'h0000, acc_in, dsc_addr, dsc_wdata, dsc_rdata, w;
	logic [3:0] jmp;
	logic [8:0] me, tt_wchar;
	logic reply, reject, dsc_req, dsc_we, dsc_ack, tt_wmot, tt_rmot, tt_eor, tt_wstb;
	logic [7:0] tt_rchar = 8'h00, req_count;
	logic tt_rstb = 1'b0, tt_ready = 1'b1, tt_gap_done = 1'b0, tt_block = 1'b0, tt_at_gap = 1'b0;
	logic [1:0] tt_unit;
	logic [17:0] notes[$], n;
	logic [8:0] chars[$];
	logic [31:0] mw[$], m;
	logic acc_pend = 1'b0;
	logic [15:0] acc_exp;
	integer seed = 32'h4497_ab07;
	int fail_count = 0, cmp_count = 0, eor_count = 0;
	// ==========================================
	// Design and partner
	tape_ctrl_host_command_decode #(.CONT_CYCLES(CONT)) dut_u (.CLK(clk), .RST_B(rst_b), .IO_OUT(io_out),
		.IO_IN(io_in), .SEL_WORD(sel_word), .ACC_OUT(acc_out), .PROTECT_FAULT(protect_fault), .REPLY(reply),
		.REJECT(reject), .ACC_IN(acc_in), .EQUIP_JUMPER(jmp), .DSC_REQ(dsc_req), .DSC_WE(dsc_we),
		.DSC_ADDR(dsc_addr), .DSC_WDATA(dsc_wdata), .DSC_RDATA(dsc_rdata), .DSC_ACK(dsc_ack), .TT_UNIT(tt_unit),
		.TT_WRITE_MOTION(tt_wmot), .TT_READ_MOTION(tt_rmot), .TT_EOR(tt_eor), .TT_WCHAR(tt_wchar),
		.TT_WSTB(tt_wstb), .TT_RCHAR(tt_rchar), .TT_RSTB(tt_rstb), .TT_READY(tt_ready),
		.TT_GAP_DONE(tt_gap_done), .TT_BLOCK(tt_block), .TT_AT_GAP(tt_at_gap));
	host_mem_model #(.START(16'h0100), .LAST(16'h0103)) mem_u (.CLK(clk), .RST_B(rst_b), .DSC_REQ(dsc_req),
		.DSC_WE(dsc_we), .DSC_ADDR(dsc_addr), .DSC_WDATA(dsc_wdata), .DSC_RDATA(dsc_rdata), .DSC_ACK(dsc_ack),
		.REQ_COUNT(req_count));
	always #12.5 clk = ~clk;
	// ==========================================
	// Helpers
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Kind 0 none, 1 reply, 2 reject, 3 reply with input word
	task automatic io(input logic out, input logic [1:0] d, input logic [15:0] a, input logic [1:0] kind,
		input logic [15:0] exp, input logic [8:0] top);
		if (kind != 2'h0) notes.push_back({kind, exp});
		sel_word <= {top, 5'($random(seed)), d};
		acc_out <= a;
		io_out <= out;
		io_in <= !out;
		@(posedge clk);
		io_out <= 1'b0;
		io_in <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic word_chars(input logic [15:0] v);
		chars.push_back({~^v[15:8], v[15:8]});
		chars.push_back({~^v[7:0], v[7:0]});
	endtask
	task automatic rchar(input logic [7:0] c);
		tt_rchar <= c;
		@(posedge clk);
		tt_rstb <= 1'b1;
		repeat (4) @(posedge clk);
		tt_rstb <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	// ==========================================
	// Monitor
	always @(posedge clk) begin
		if (acc_pend) begin
			check(acc_in, acc_exp);
			acc_pend = 1'b0;
		end
		if (reply === 1'b1 || reject === 1'b1) begin
			n = (notes.size() != 0) ? notes.pop_front() : 18'h0_0000;
			check({14'h0000, reject, reply}, (n[17:16] == 2'h2) ? 16'h0002 : {15'h0000, n[17:16] != 2'h0});
			acc_pend = (n[17:16] == 2'h3);
			acc_exp = n[15:0];
		end
		if (tt_wstb === 1'b1) check({7'h00, tt_wchar}, (chars.size() != 0) ? {7'h00, chars.pop_front()} : 16'hffff);
		// Storage writes are looked at while ack stands
		if (dsc_ack === 1'b1 && dsc_we === 1'b1) begin
			m = (mw.size() != 0) ? mw.pop_front() : 32'hffff_ffff;
			check(dsc_addr, m[31:16]);
			check(dsc_wdata, m[15:0]);
		end
		if (tt_eor === 1'b1) eor_count++;
	end
	initial begin
		#125000;
		fail_count++;
		$display("[ERR] %0t watchdog expired", $time);
		complete_run;
	end
	// ==========================================
	// Scenarios
	initial begin
		jmp = 4'($random(seed));
		me = {5'h00, jmp};
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		check({11'h000, dsc_req, tt_wmot, tt_rmot, reply, reject}, 16'h0000);
		io(1'b0, 2'h1, 16'h0000, 2'h3, 16'h0001, me);
		io(1'b0, 2'h1, 16'h0000, 2'h0, 16'h0000, {5'h10, jmp});
		io(1'b0, 2'h1, 16'h0000, 2'h0, 16'h0000, {5'h00, jmp ^ 4'h9});
		io(1'b1, 2'h0, 16'h1234, 2'h2, 16'h0000, me);
		io(1'b1, 2'h2, 16'h0200, 2'h2, 16'h0000, me);
		io(1'b1, 2'h2, 16'h0180, 2'h1, 16'h0000, me);
		check({14'h0000, tt_unit}, 16'h0003);
		io(1'b0, 2'h2, 16'h0000, 2'h3, 16'h0003, me);
		io(1'b1, 2'h1, 16'h0180, 2'h2, 16'h0000, me);
		protect_fault <= 1'b1;
		io(1'b1, 2'h1, 16'h0080, 2'h2, 16'h0000, me);
		protect_fault <= 1'b0;
		io(1'b1, 2'h1, 16'h0080, 2'h1, 16'h0000, me);
		check({15'h0000, tt_wmot}, 16'h0001);
		io(1'b1, 2'h0, 16'h00ff, 2'h2, 16'h0000, me);
		tt_gap_done <= 1'b1;
		repeat (5) @(posedge clk);
		// Two writes well inside the continuity window make one record
		for (int i = 0; i < 2; i++) begin
			w = 16'($random(seed));
			word_chars(w);
			io(1'b1, 2'h0, w, 2'h1, 16'h0000, me);
		end
		tt_ready <= 1'b0;
		repeat (3) @(posedge clk);
		io(1'b1, 2'h0, 16'h3333, 2'h2, 16'h0000, me);
		tt_ready <= 1'b1;
		repeat (3) @(posedge clk);
		protect_fault <= 1'b1;
		io(1'b1, 2'h0, 16'h0f0f, 2'h2, 16'h0000, me);
		protect_fault <= 1'b0;
		check(16'(eor_count), 16'h0000);
		repeat (CONT + 10) @(posedge clk);
		check(16'(eor_count), 16'h0001);
		check(16'(chars.size()), 16'h0000);
		tt_at_gap <= 1'b1;
		repeat (6) @(posedge clk);
		check({15'h0000, tt_wmot}, 16'h0000);
		tt_at_gap <= 1'b0;
		tt_gap_done <= 1'b0;
		repeat (4) @(posedge clk);
		io(1'b1, 2'h1, 16'h0100, 2'h1, 16'h0000, me);
		check({15'h0000, tt_rmot}, 16'h0001);
		io(1'b0, 2'h0, 16'h0000, 2'h2, 16'h0000, me);
		tt_block <= 1'b1;
		w = 16'($random(seed));
		rchar(w[15:8]);
		rchar(w[7:0]);
		io(1'b0, 2'h0, 16'h0000, 2'h3, w, me);
		tt_at_gap <= 1'b1;
		tt_block <= 1'b0;
		repeat (6) @(posedge clk);
		check({15'h0000, tt_rmot}, 16'h0000);
		tt_at_gap <= 1'b0;
		repeat (4) @(posedge clk);
		// Buffered write: end address first, no data before the gap
		io(1'b1, 2'h3, 16'h0100, 2'h1, 16'h0000, me);
		repeat (10) @(posedge clk);
		check({8'h00, req_count}, 16'h0001);
		io(1'b1, 2'h0, 16'h5555, 2'h2, 16'h0000, me);
		for (logic [15:0] a = 16'h0100; a < 16'h0103; a++) word_chars(a ^ 16'h3c3c);
		io(1'b1, 2'h1, 16'h0080, 2'h1, 16'h0000, me);
		repeat (10) @(posedge clk);
		check({8'h00, req_count}, 16'h0001);
		check(16'(chars.size()), 16'h0006);
		tt_gap_done <= 1'b1;
		for (int i = 0; i < 400 && chars.size() != 0; i++) @(posedge clk);
		check(16'(chars.size()), 16'h0000);
		check({8'h00, req_count}, 16'h0004);
		rst_b <= 1'b0;
		tt_gap_done <= 1'b0;
		repeat (2) @(posedge clk);
		check({14'h0000, tt_wmot, dsc_req}, 16'h0000);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		io(1'b0, 2'h1, 16'h0000, 2'h3, 16'h0001, me);
		// Buffered read: a character before the block must be ignored
		io(1'b1, 2'h3, 16'h0100, 2'h1, 16'h0000, me);
		io(1'b1, 2'h1, 16'h0100, 2'h1, 16'h0000, me);
		rchar(8'h5a);
		check({8'h00, req_count}, 16'h0001);
		tt_block <= 1'b1;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 2; i++) begin
			w = 16'($random(seed));
			mw.push_back({16'(256 + i), w});
			rchar(w[15:8]);
			rchar(w[7:0]);
		end
		repeat (8) @(posedge clk);
		check({8'h00, req_count}, 16'h0003);
		check(16'(mw.size()), 16'h0000);
		io(1'b0, 2'h3, 16'h0000, 2'h3, 16'h0102, me);
		// Clear in mid transfer drops buffered mode and motion
		io(1'b1, 2'h1, 16'h0001, 2'h1, 16'h0000, me);
		io(1'b0, 2'h1, 16'h0000, 2'h3, 16'h0001, me);
		tt_block <= 1'b0;
		repeat (4) @(posedge clk);
		complete_run;
	end
endmodule
